// >>> rtl/rcal_rtc.sv
// Compensated seconds counter with alarm, update mode, lock and interrupt, Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module rcal_rtc import rcal_pkg::*; #(
  parameter int LOSS_CYCLES = XTAL_LOSS_CYCLES
) (
  input wire logic ref_clk, // System clock, 25 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire rcal_wb_req_t wbReq, // Wishbone request group
  output logic wb_ack_o, // Wishbone acknowledge
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic xtalClk, // 32.768 kHz crystal clock, asynchronous
  output logic secClkOut, // 1 Hz seconds clock pin
  output logic irqOut, // Level interrupt
  output logic secIrqOut // One-cycle seconds interrupt pulse
);

  initial begin
    if (LOSS_CYCLES < 2 || LOSS_CYCLES > 4095) begin
      $error("LOSS_CYCLES out of range");
    end
  end

  typedef struct packed {
    rcal_regs_t regs;
    logic softRst;
    logic xtalSync1;
    logic xtalSync2;
    logic xtalPrev;
    logic [11:0] lossCnt;
    logic xtalOk;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic secIrq;
  } rcal_state_t;

  localparam logic [11:0] LOSS_LAST = 12'(LOSS_CYCLES - 1);

  rcal_state_t state_reg;
  rcal_state_t state_next;

  function automatic logic regHit(input logic [31:0] adr, input logic [7:0] off);
    regHit = (adr[31:8] == 24'h0) && (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[8*i +: 8] = sel[i] ? wdat[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  rcal_regs_t r;
  logic access;
  logic wrAcc;
  logic xtalEdge;
  logic running;
  logic tick;
  logic compApply;
  logic [15:0] prescNew;
  logic secIncr;
  logic alarmHit;
  logic cenWritable;
  logic anyIrq;
  logic timeBad;

  logic [14:0] compTarget;

  assign r = state_reg.regs;
  assign access = wbReq.cyc & wbReq.stb & ~state_reg.ack;
  assign wrAcc = access & wbReq.we;
  assign xtalEdge = state_reg.xtalSync2 & ~state_reg.xtalPrev;
  assign timeBad = r.timeInv | r.timeOvf;
  assign running = r.cntEn & ~timeBad & state_reg.xtalOk; // RULE_22
  assign tick = running & xtalEdge;
  // Compensation only in the first second of an interval, never with a zero value
  assign compApply = tick && (r.presc[14:0] == PRESC_COMP_POINT) && r.firstSec
                     && (r.actComp != 8'h0); // RULE_02 RULE_05 RULE_06
  // Landing count after the compensation point: nominal plus the signed value
  assign compTarget = 15'(PRESC_NOMINAL_NEXT + {{7{r.actComp[7]}}, r.actComp}); // RULE_01
  // Next prescaler: skip or repeat counts by the signed value
  assign prescNew = compApply ? {r.presc[15], compTarget} : 16'(r.presc + 16'h1);
  assign secIncr = tick & r.presc[14] & ~prescNew[14]; // RULE_21
  assign alarmHit = secIncr && (r.secs == r.alarm); // RULE_08
  assign cenWritable = r.stl | (r.updMode & (~r.cntEn | timeBad)); // RULE_11 RULE_12 RULE_13
  assign anyIrq = (r.timeInv & r.tiie) | (r.timeOvf & r.toie) | (r.almFlag & r.almIe); // RULE_10 RULE_18

  always_comb begin
    logic [31:0] wval;
    logic [31:0] rval;
    logic keepSoft;
    wval = 32'h0;
    rval = 32'h0;
    keepSoft = 1'b0;
    state_next = state_reg;

    // Crystal edge detection and presence watchdog
    state_next.xtalSync1 = xtalClk;
    state_next.xtalSync2 = state_reg.xtalSync1;
    state_next.xtalPrev = state_reg.xtalSync2;
    if (xtalEdge) begin
      state_next.lossCnt = 12'h0;
      state_next.xtalOk = 1'b1;
    end else if (state_reg.lossCnt == LOSS_LAST) begin
      state_next.xtalOk = 1'b0;
    end else begin
      state_next.lossCnt = 12'(state_reg.lossCnt + 12'h1);
    end

    // Time counter
    if (tick) begin
      state_next.regs.presc = prescNew;
    end
    if (secIncr) begin
      state_next.regs.secs = 32'(r.secs + 32'h1);
      if (r.secs == SECONDS_MAX) begin
        state_next.regs.timeOvf = 1'b1;
      end
      // Pending setting loads only when the running interval has expired
      if (r.intCnt == 8'h0) begin
        state_next.regs.actComp = r.tcrComp; // RULE_04
        state_next.regs.intCnt = r.tcrIntv; // RULE_03
        state_next.regs.firstSec = 1'b1;
      end else begin
        state_next.regs.intCnt = 8'(r.intCnt - 8'h1);
        state_next.regs.firstSec = 1'b0; // RULE_05
      end
    end

    // Bus writes; locked targets drop the data and still acknowledge
    if (wrAcc) begin
      if (regHit(wbReq.adr, OFF_SECONDS)) begin
        if (!r.cntEn) begin
          state_next.regs.secs = mergeBytes(r.secs, wbReq.dat, wbReq.sel);
          state_next.regs.timeInv = 1'b0;
          state_next.regs.timeOvf = 1'b0;
        end
      end
      if (regHit(wbReq.adr, OFF_PRESCALER)) begin
        if (!r.cntEn) begin
          wval = mergeBytes({16'h0, r.presc}, wbReq.dat, wbReq.sel);
          state_next.regs.presc = wval[15:0];
        end
      end
      if (regHit(wbReq.adr, OFF_ALARM)) begin
        state_next.regs.alarm = mergeBytes(r.alarm, wbReq.dat, wbReq.sel);
        state_next.regs.almFlag = 1'b0; // RULE_09
      end
      if (regHit(wbReq.adr, OFF_COMP) && r.tcl) begin // RULE_14 RULE_17
        wval = mergeBytes({16'h0, r.tcrIntv, r.tcrComp}, wbReq.dat, wbReq.sel);
        state_next.regs.tcrComp = wval[COMP_VAL_LSB +: 8];
        state_next.regs.tcrIntv = wval[COMP_INT_LSB +: 8];
      end
      if (regHit(wbReq.adr, OFF_CONTROL) && r.crl) begin // RULE_14 RULE_15
        wval = mergeBytes({28'h0, r.updMode, 2'h0, state_reg.softRst}, wbReq.dat, wbReq.sel);
        state_next.softRst = wval[CTRL_SOFT_BIT];
        state_next.regs.updMode = wval[CTRL_UPD_BIT];
      end
      if (regHit(wbReq.adr, OFF_STATUS) && wbReq.sel[0] && cenWritable) begin // RULE_11 RULE_12 RULE_13
        state_next.regs.cntEn = wbReq.dat[STAT_CEN_BIT];
      end
      if (regHit(wbReq.adr, OFF_LOCK) && wbReq.sel[0] && r.lrl) begin // RULE_16
        // Lock bits only ever clear from software
        state_next.regs.tcl = r.tcl & wbReq.dat[LOCK_COMP_BIT]; // RULE_14
        state_next.regs.crl = r.crl & wbReq.dat[LOCK_CTRL_BIT];
        state_next.regs.stl = r.stl & wbReq.dat[LOCK_STAT_BIT];
        state_next.regs.lrl = r.lrl & wbReq.dat[LOCK_LOCK_BIT];
      end
      if (regHit(wbReq.adr, OFF_IRQ_EN) && wbReq.sel[0]) begin
        state_next.regs.tiie = wbReq.dat[IEN_TIIE_BIT];
        state_next.regs.toie = wbReq.dat[IEN_TOIE_BIT];
        state_next.regs.almIe = wbReq.dat[IEN_ALM_BIT];
        state_next.regs.secIe = wbReq.dat[IEN_SEC_BIT];
      end
    end

    // A match in the clearing cycle still raises the flag
    if (alarmHit) begin
      state_next.regs.almFlag = 1'b1; // RULE_08
    end

    // Software reset holds the register set, but not its own bit, at its reset state
    if (state_reg.softRst) begin
      keepSoft = state_next.softRst;
      state_next.regs = RCAL_REGS_RST; // RULE_14 RULE_23
      state_next.softRst = keepSoft;
    end

    // Bus read path
    unique case (1'b1)
      regHit(wbReq.adr, OFF_SECONDS): rval = timeBad ? 32'h0 : r.secs;
      regHit(wbReq.adr, OFF_PRESCALER): rval = timeBad ? 32'h0 : {16'h0, r.presc};
      regHit(wbReq.adr, OFF_ALARM): rval = r.alarm;
      regHit(wbReq.adr, OFF_COMP): rval = {16'h0, r.tcrIntv, r.tcrComp};
      regHit(wbReq.adr, OFF_CONTROL): rval = {28'h0, r.updMode, 2'h0, state_reg.softRst};
      regHit(wbReq.adr, OFF_STATUS): rval = {27'h0, r.cntEn, 1'b0, r.almFlag, r.timeOvf, r.timeInv};
      regHit(wbReq.adr, OFF_LOCK): rval = {25'h0, r.lrl, r.stl, r.crl, r.tcl, LOCK_RSVD_VAL};
      regHit(wbReq.adr, OFF_IRQ_EN): rval = {27'h0, r.secIe, 1'b0, r.almIe, r.toie, r.tiie};
      default: rval = 32'h0;
    endcase
    state_next.ack = access;
    state_next.rdat = (access && !wbReq.we) ? rval : 32'h0;

    state_next.irq = anyIrq; // RULE_18 RULE_19 RULE_24
    state_next.secIrq = secIncr & r.secIe; // RULE_20
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{regs: RCAL_REGS_RST, softRst: 1'b0, xtalSync1: 1'b0, xtalSync2: 1'b0,
                     xtalPrev: 1'b0, lossCnt: 12'h0, xtalOk: 1'b0, ack: 1'b0,
                     rdat: 32'h0, irq: 1'b0, secIrq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdat;
  assign secClkOut = state_reg.regs.presc[14]; // RULE_07
  assign irqOut = state_reg.irq;
  assign secIrqOut = state_reg.secIrq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Alarm flag
  chk_alarm_sets: assert property (alarmHit |=> r.almFlag) // RULE_08
    else $error("alarm flag missed on match");

  chk_alarm_write_clear: assert property (
    wrAcc && regHit(wbReq.adr, OFF_ALARM) && !alarmHit && !state_reg.softRst |=> !r.almFlag) // RULE_09
    else $error("alarm write did not clear flag");

  chk_alarm_keep: assert property (
    !alarmHit && !(wrAcc && regHit(wbReq.adr, OFF_ALARM)) && !state_reg.softRst
    |=> $stable(r.almFlag)) // RULE_09
    else $error("alarm flag changed without match or write");

  // Interrupts
  chk_irq_level: assert property (1'b1 |=> irqOut == $past(anyIrq)) // RULE_24
    else $error("interrupt level not registered OR of flags");

  chk_sec_pulse: assert property (secIrqOut |=> !secIrqOut) // RULE_20
    else $error("seconds interrupt longer than one cycle");

  chk_sec_irq_on: assert property (secIncr && r.secIe |=> secIrqOut) // RULE_20
    else $error("seconds interrupt missing at increment");

  chk_sec_irq_off: assert property (!secIncr |=> !secIrqOut) // RULE_20
    else $error("seconds interrupt without increment");

  // Prescaler and compensation
  chk_presc_hold: assert property (
    !running && !wrAcc && !state_reg.softRst |=> r.presc == $past(r.presc)) // RULE_22
    else $error("prescaler moved while stopped");

  chk_presc_step: assert property (
    tick && !compApply && !state_reg.softRst
    |=> r.presc == 16'($past(r.presc) + 16'h1)) // RULE_22
    else $error("prescaler did not step by one");

  chk_comp_jump: assert property (
    compApply && !state_reg.softRst
    |=> r.presc[14:0] == $past(compTarget)) // RULE_02
    else $error("compensation jump wrong");

  chk_comp_range: assert property (
    compApply |-> compTarget >= 15'h3f80 && compTarget <= 15'h407f) // RULE_01
    else $error("compensation outside allowed cycle range");

  chk_zero_nominal: assert property (
    tick && r.actComp == 8'h0 && r.presc[14:0] == PRESC_COMP_POINT && !state_reg.softRst
    |=> r.presc[14:0] == PRESC_NOMINAL_NEXT) // RULE_06
    else $error("zero compensation altered second");

  chk_late_nominal: assert property (
    tick && !r.firstSec && r.presc[14:0] == PRESC_COMP_POINT && !state_reg.softRst
    |=> r.presc[14:0] == PRESC_NOMINAL_NEXT) // RULE_05
    else $error("compensation outside first second");

  chk_interval_load: assert property (
    secIncr && r.intCnt == 8'h0 && !state_reg.softRst
    |=> r.firstSec && r.actComp == $past(r.tcrComp) && r.intCnt == $past(r.tcrIntv)) // RULE_03 RULE_04
    else $error("pending compensation not loaded");

  chk_interval_count: assert property (
    secIncr && r.intCnt != 8'h0 && !state_reg.softRst
    |=> !r.firstSec && r.intCnt == 8'($past(r.intCnt) - 8'h1)) // RULE_03 RULE_05
    else $error("interval counter wrong");

  chk_comp_stable: assert property (
    !secIncr && !state_reg.softRst |=> $stable(r.actComp) && $stable(r.firstSec)) // RULE_04
    else $error("compensation changed between increments");

  // Seconds counter
  chk_sec_incr: assert property (
    secIncr && !state_reg.softRst |=> r.secs == 32'($past(r.secs) + 32'h1)) // RULE_21
    else $error("seconds did not advance");

  chk_sec_idle: assert property (
    !secIncr && !wrAcc && !state_reg.softRst |=> $stable(r.secs)) // RULE_21
    else $error("seconds moved without increment");

  chk_overflow_stop: assert property (
    secIncr && r.secs == SECONDS_MAX && !state_reg.softRst |=> r.timeOvf && !running) // RULE_22
    else $error("overflow did not stop counting");

  chk_invalid_zero: assert property (
    access && !wbReq.we && regHit(wbReq.adr, OFF_SECONDS) && timeBad |=> wb_dat_o == 32'h0) // RULE_23
    else $error("seconds readable while invalid");

  // Counter enable guard
  chk_cen_guard: assert property (
    wrAcc && regHit(wbReq.adr, OFF_STATUS) && !cenWritable && !state_reg.softRst
    |=> $stable(r.cntEn)) // RULE_11
    else $error("counter enable written while guarded");

  chk_update_mode: assert property (
    wrAcc && regHit(wbReq.adr, OFF_STATUS) && wbReq.sel[0] && r.updMode && !r.cntEn
    && !state_reg.softRst |=> r.cntEn == $past(wbReq.dat[STAT_CEN_BIT])) // RULE_12
    else $error("update mode write to counter enable lost");

  // Locks
  chk_lock_sticky: assert property (!r.lrl && !state_reg.softRst |=> $stable(r.tcl) && !r.lrl) // RULE_16
    else $error("lock register changed while locked");

  chk_lock_set_only: assert property (
    !state_reg.softRst
    |=> (!r.tcl || $past(r.tcl)) && (!r.crl || $past(r.crl)) && (!r.stl || $past(r.stl))) // RULE_14
    else $error("lock bit reopened without reset");

  chk_comp_locked: assert property (
    wrAcc && regHit(wbReq.adr, OFF_COMP) && !r.tcl && !state_reg.softRst
    |=> $stable(r.tcrComp) && $stable(r.tcrIntv)) // RULE_17
    else $error("locked compensation register written");

  chk_ctrl_locked: assert property (
    wrAcc && regHit(wbReq.adr, OFF_CONTROL) && !r.crl && !state_reg.softRst
    |=> $stable(r.updMode)) // RULE_14
    else $error("locked control register written");

  chk_ack_pulse: assert property (access |=> wb_ack_o ##1 !wb_ack_o) // RULE_17
    else $error("access not acknowledged for one cycle");

  // Software reset
  chk_soft_blocked: assert property (!r.crl && !state_reg.softRst |=> !state_reg.softRst) // RULE_15
    else $error("software reset while control locked");

  chk_soft_invalid: assert property (state_reg.softRst |=> r.timeInv ##1 irqOut) // RULE_19 RULE_23
    else $error("software reset left time valid or no interrupt");

  chk_soft_wipe: assert property (
    state_reg.softRst |=> r.secs == 32'h0 && r.tcl && r.crl && r.stl && r.lrl) // RULE_14 RULE_23
    else $error("software reset left registers or locks");

endmodule
`default_nettype wire

// >>> shared/rcal_pkg.sv
// Constants and types for the compensated seconds counter with alarm and lock
// Functional notes
// RULE_01: Compensation shifts second by minus 127 to 128
// RULE_02: Adjust cycles when prescaler leaves 0x3FFF
// RULE_03: Interval selectable from 1 to 256 seconds
// RULE_04: New setting waits for increment and expired interval
// RULE_05: Only first second of interval is compensated
// RULE_06: Zero compensation value means nominal seconds
// RULE_07: Seconds clock driven onto output pin
// RULE_08: Alarm flag sets on match at increment
// RULE_09: Alarm write clears flag; past value never matches
// RULE_10: Alarm flag always works; enable gates interrupt
// RULE_11: Without update mode, enable writable only unlocked
// RULE_12: Update mode also allows when stopped or invalid
// RULE_13: Unlocked status register ignores update mode
// RULE_14: Locked registers stay locked until any reset
// RULE_15: Locked control register disables software reset
// RULE_16: Locked lock register cannot change until reset
// RULE_17: Locked writes dropped silently, no bus error
// RULE_18: Interrupt when any flag and enable set
// RULE_19: Interrupt asserted after power-on and software reset
// RULE_20: Seconds pulse each second when enabled, no flag
// RULE_21: Seconds advance on prescaler bit 14 falling
// RULE_22: Prescaler runs only enabled, valid, crystal present
// RULE_23: Invalid flag set by power-on and software reset
// RULE_24: Interrupt is registered OR of enabled flags
package rcal_pkg;

  localparam logic [7:0] OFF_SECONDS = 8'h00;
  localparam logic [7:0] OFF_PRESCALER = 8'h04;
  localparam logic [7:0] OFF_ALARM = 8'h08;
  localparam logic [7:0] OFF_COMP = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_LOCK = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1c;

  // Compensation register: value in 7:0, interval in 15:8
  localparam int COMP_VAL_LSB = 0;
  localparam int COMP_INT_LSB = 8;
  // Control register
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_UPD_BIT = 3;
  // Status register
  localparam int STAT_INV_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_ALM_BIT = 2;
  localparam int STAT_CEN_BIT = 4;
  // Lock register, a one means unlocked
  localparam int LOCK_COMP_BIT = 3;
  localparam int LOCK_CTRL_BIT = 4;
  localparam int LOCK_STAT_BIT = 5;
  localparam int LOCK_LOCK_BIT = 6;
  localparam logic [2:0] LOCK_RSVD_VAL = 3'h7;
  // Interrupt enable register
  localparam int IEN_TIIE_BIT = 0;
  localparam int IEN_TOIE_BIT = 1;
  localparam int IEN_ALM_BIT = 2;
  localparam int IEN_SEC_BIT = 4;

  localparam logic [14:0] PRESC_COMP_POINT = 15'h3fff;
  localparam logic [14:0] PRESC_NOMINAL_NEXT = 15'h4000;
  localparam logic [31:0] SECONDS_MAX = 32'hffffffff;

  // Crystal considered lost after this long without an edge
  localparam int XTAL_LOSS_NS = 100000;
  localparam int REF_CLK_PERIOD_NS = 40;
  localparam int XTAL_LOSS_CYCLES = XTAL_LOSS_NS / REF_CLK_PERIOD_NS;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rcal_wb_req_t;

  typedef struct packed {
    logic [31:0] secs;
    logic [15:0] presc;
    logic [31:0] alarm;
    logic [7:0] tcrComp;
    logic [7:0] tcrIntv;
    logic [7:0] actComp;
    logic [7:0] intCnt;
    logic firstSec;
    logic updMode;
    logic timeInv;
    logic timeOvf;
    logic almFlag;
    logic cntEn;
    logic tcl;
    logic crl;
    logic stl;
    logic lrl;
    logic tiie;
    logic toie;
    logic almIe;
    logic secIe;
  } rcal_regs_t;

  localparam rcal_regs_t RCAL_REGS_RST = '{
    secs: 32'h0, presc: 16'h0, alarm: 32'h0,
    tcrComp: 8'h0, tcrIntv: 8'h0, actComp: 8'h0, intCnt: 8'h0,
    firstSec: 1'b0, updMode: 1'b0, timeInv: 1'b1, timeOvf: 1'b0, almFlag: 1'b0, cntEn: 1'b0,
    tcl: 1'b1, crl: 1'b1, stl: 1'b1, lrl: 1'b1,
    tiie: 1'b1, toie: 1'b1, almIe: 1'b1, secIe: 1'b0
  };

endpackage

// >>> test/testbench.sv
// Self-checking testbench for the compensated seconds counter
`timescale 1ns/1ps
`default_nettype none
module testbench import rcal_pkg::*;;
  logic ref_clk;
  logic rst_b;
  rcal_wb_req_t wbReq;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic xtalClk;
  logic secClkOut;
  logic irqOut;
  logic secIrqOut;
  logic [31:0] expQ[$];
  int n_fail = 0;
  int n_compared = 0;
  int nSecIrq = 0;
  int cycles = 0;
  logic [15:0] lfsrReg = 16'h259f;
  logic [31:0] secsVal;
  logic [15:0] compWord[4] = '{16'h007f, 16'h0080, 16'h017f, 16'h0000};
  logic [15:0] compExp1[4] = '{16'h407f, 16'h3f80, 16'h407f, 16'h4000};
  logic [15:0] compExp2[4] = '{16'h407f, 16'h3f80, 16'h4000, 16'h4000};

  rcal_rtc #(.LOSS_CYCLES(4000)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .wbReq(wbReq), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .xtalClk(xtalClk), .secClkOut(secClkOut), .irqOut(irqOut), .secIrqOut(secIrqOut));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Read data is compared when the acknowledge shows up
  always @(posedge ref_clk) begin
    cycles++;
    if (secIrqOut === 1'b1) nSecIrq++;
    if (wb_ack_o === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0) check(wb_dat_o, expQ.pop_front());
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wbReq <= {1'b1, 1'b1, we, {24'h0, adr}, 4'hf, dat};
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      xtalClk <= 1'b1;
      repeat (5) @(posedge ref_clk);
      xtalClk <= 1'b0;
      repeat (5) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irqOut}, {31'h0, e});
  endtask

  // One seconds increment from just below the bit 14 fall
  task automatic incr();
    wr(OFF_STATUS, 32'h0);
    wr(OFF_PRESCALER, 32'h7ffe);
    wr(OFF_STATUS, 32'h10);
    ticks(2);
  endtask

  // Two ticks across the compensation point
  task automatic measure(input logic [15:0] e);
    wr(OFF_STATUS, 32'h0);
    wr(OFF_PRESCALER, 32'h3ffe);
    wr(OFF_STATUS, 32'h10);
    ticks(2);
    rd(OFF_PRESCALER, {16'h0, e});
    check({31'h0, secClkOut}, {31'h0, e[14]});
  endtask

  initial begin
    wbReq = '0;
    xtalClk = 1'b0;
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    irq_is(1'b1);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_LOCK, 32'h7f);
    rd(OFF_IRQ_EN, 32'h7);
    rd(8'h20, 32'h0);
    ticks(3);
    lfsrReg = lfsr_next(lfsrReg);
    secsVal = {1'b0, lfsrReg[14:0], lfsrReg};
    wr(OFF_SECONDS, secsVal);
    wr(OFF_ALARM, secsVal);
    wr(OFF_IRQ_EN, 32'h14);
    irq_is(1'b0);
    incr();
    check(32'(nSecIrq), 32'h1);
    rd(OFF_SECONDS, secsVal + 32'h1);
    rd(OFF_STATUS, 32'h14);
    check({31'h0, secClkOut}, 32'h0);
    irq_is(1'b1);
    wr(OFF_IRQ_EN, 32'h10);
    wr(OFF_ALARM, 32'h0);
    rd(OFF_STATUS, 32'h10);
    wr(OFF_ALARM, secsVal + 32'h1);
    incr();
    rd(OFF_STATUS, 32'h14);
    irq_is(1'b0);
    wr(OFF_ALARM, 32'h0);
    wr(OFF_IRQ_EN, 32'h0);
    incr();
    check(32'(nSecIrq), 32'h2);
    rd(OFF_STATUS, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_COMP, {16'h0, compWord[i]});
      incr();
      measure(compExp1[i]);
      incr();
      measure(compExp2[i]);
    end
    wr(OFF_STATUS, 32'h0);
    wr(OFF_LOCK, 32'h5f);
    rd(OFF_LOCK, 32'h5f);
    wr(OFF_STATUS, 32'h10);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CONTROL, 32'h8);
    wr(OFF_STATUS, 32'h10);
    rd(OFF_STATUS, 32'h10);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h10);
    wr(OFF_LOCK, 32'h4f);
    wr(OFF_CONTROL, 32'h1);
    rd(OFF_CONTROL, 32'h8);
    rd(OFF_STATUS, 32'h10);
    wr(OFF_LOCK, 32'h0f);
    wr(OFF_LOCK, 32'h07);
    rd(OFF_LOCK, 32'h0f);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(OFF_LOCK, 32'h7f);
    wr(OFF_SECONDS, 32'h5);
    irq_is(1'b0);
    wr(OFF_PRESCALER, 32'h10);
    ticks(2);
    rd(OFF_PRESCALER, 32'h10);
    wr(OFF_CONTROL, 32'h8);
    wr(OFF_STATUS, 32'h10);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_LOCK, 32'h77);
    wr(OFF_COMP, 32'h1234);
    rd(OFF_COMP, 32'h0);
    wr(OFF_CONTROL, 32'h1);
    irq_is(1'b1);
    wr(OFF_CONTROL, 32'h0);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_LOCK, 32'h7f);
    rd(OFF_SECONDS, 32'h0);
    repeat (5) @(posedge ref_clk);
    check(32'(expQ.size()), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
